// ==== design/pin_mux.sv ====
// Port 1 / port 2 pin-function multiplexer with APB register access.
// Assumes pin inputs are asynchronous; on-chip serial/interrupt logic shares clk.
// Pin drive is combinational so serial functions see no extra delay on the way out.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
module pin_mux
(
   input wire logic clk, // 10 MHz system clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic [7:0] port1PinIn, // Port 1 pin levels
   output logic [7:0] port1PinOut, // Port 1 pin drive value
   output logic [7:0] port1PinOe, // Port 1 pin output enable
   input wire logic [2:0] port2PinIn, // Port 2 pin levels
   output logic [2:0] port2PinOut, // Port 2 pin drive value
   output logic [2:0] port2PinOe, // Port 2 pin output enable
   input wire logic txData, // Serial transmit data to P22
   output logic rxData, // Serial receive data from P21
   input wire logic serialClockOut, // Serial clock to drive on P20
   output logic serialClockIn, // Serial clock sampled from P20
   input wire logic serialClockOutCh3, // Third channel clock to drive on P12
   output logic serialClockInCh3, // Third channel clock sampled from P12
   output logic extInterrupt3, // P17 level to interrupt 3
   output logic timerTriggerIn, // P17 level to timer trigger
   output logic extInterrupt0 // P14 level to interrupt 0
);
   typedef struct packed {
      logic [7:0] modeSelect;
      logic [7:0] p1Dir;
      logic [7:0] p1Data;
      logic [7:0] p2Dir;
      logic [7:0] p2Data;
      logic [7:0] serialCtrl;
      logic [31:0] rdata;
      logic [10:0] sync1;
      logic [10:0] sync2;
   } state_t;

   state_t s_reg;
   state_t s_next;
   logic [7:0] p1Live;
   logic [2:0] p2Live;
   logic [7:0] p1Rd;
   logic [7:0] p2Rd;
   logic mapped;
   logic p20ClkIn;
   logic p20ClkOut;
   logic p12ClkIn;
   logic p12ClkOut;
   logic txSel;
   logic rxSel;
   logic int3Sel;
   logic int0Sel;

   // Serial clock pin role from clock enables and sync mode
   function automatic logic [1:0] clkRole(logic enHi, logic enLo, logic syncMode);
      // [1]=input role, [0]=output role; the high enable wins so an external
      // clock can never fight an internally generated one
      clkRole = {enHi, ~enHi & (enLo | syncMode)};
   endfunction

   // Read mux: latched data for outputs, live level for inputs
   function automatic logic [7:0] portRead(logic [7:0] dir, logic [7:0] data, logic [7:0] pin);
      portRead = (dir & data) | (~dir & pin);
   endfunction

   // True for every implemented register offset
   function automatic logic isMapped(logic [11:0] addr);
      case (addr)
         pin_mux_pkg::PORT1_MODE_SELECT_OFS,
         pin_mux_pkg::PORT1_DIRECTION_OFS,
         pin_mux_pkg::PORT1_DATA_OFS,
         pin_mux_pkg::PORT2_DIRECTION_OFS,
         pin_mux_pkg::PORT2_OUTPUT_DATA_OFS,
         pin_mux_pkg::SERIAL_CTRL_OFS: isMapped = 1'b1;
         default: isMapped = 1'b0;
      endcase
   endfunction

   // Bit 3 of port 1 has no pin; its slot in the synchroniser is a constant 0
   assign p1Live = {s_reg.sync2[10:7], 1'b0, s_reg.sync2[6:4]};
   assign p2Live = s_reg.sync2[2:0];
   assign txSel = s_reg.modeSelect[pin_mux_pkg::MS_TXD_BIT];
   assign rxSel = s_reg.serialCtrl[pin_mux_pkg::SC_RXEN_A];
   assign int3Sel = s_reg.modeSelect[pin_mux_pkg::MS_INT3_BIT];
   assign int0Sel = s_reg.modeSelect[pin_mux_pkg::MS_INT0_BIT];
   assign {p20ClkIn, p20ClkOut} = clkRole(s_reg.serialCtrl[pin_mux_pkg::SC_CLKEN_HI_A],
      s_reg.serialCtrl[pin_mux_pkg::SC_CLKEN_LO_A],
      s_reg.serialCtrl[pin_mux_pkg::SC_COM_A]);
   assign {p12ClkIn, p12ClkOut} = clkRole(s_reg.serialCtrl[pin_mux_pkg::SC_CLKEN_HI_B],
      s_reg.serialCtrl[pin_mux_pkg::SC_CLKEN_LO_B],
      s_reg.serialCtrl[pin_mux_pkg::SC_COM_B]);
   assign p1Rd = (portRead(s_reg.p1Dir, s_reg.p1Data, p1Live) & pin_mux_pkg::PORT1_MASK)
      | pin_mux_pkg::PORT1_RESERVED_ONES;
   assign p2Rd = (portRead(s_reg.p2Dir, s_reg.p2Data, {5'h00, p2Live})
      & pin_mux_pkg::PORT2_MASK) | pin_mux_pkg::PORT2_RESERVED_ONES;
   assign mapped = isMapped(paddr);

   always_comb
   begin
      s_next = s_reg;
      // Port 1 pins 7..4 and 2..0 occupy sync bits 10..4, port 2 pins bits 2..0
      s_next.sync1[10:7] = port1PinIn[7:4];
      s_next.sync1[6:4] = port1PinIn[2:0];
      s_next.sync1[3] = 1'b0;
      s_next.sync1[2:0] = port2PinIn;
      s_next.sync2 = s_reg.sync1;
      // Read data is captured in the setup cycle so prdata is a flop output in access
      if (psel && !penable && !pwrite)
      begin
         case (paddr)
            pin_mux_pkg::PORT1_MODE_SELECT_OFS: s_next.rdata = {24'h000000, s_reg.modeSelect};
            pin_mux_pkg::PORT1_DATA_OFS: s_next.rdata = {24'h000000, p1Rd};
            pin_mux_pkg::PORT2_OUTPUT_DATA_OFS: s_next.rdata = {24'h000000, p2Rd};
            pin_mux_pkg::SERIAL_CTRL_OFS: s_next.rdata = {24'h000000, s_reg.serialCtrl};
            // Direction registers are write-only: software must keep its own copy
            pin_mux_pkg::PORT1_DIRECTION_OFS: s_next.rdata = 32'h00000000;
            pin_mux_pkg::PORT2_DIRECTION_OFS: s_next.rdata = 32'h00000000;
            // Unmapped offsets read as zero alongside the error response
            default: s_next.rdata = 32'h00000000;
         endcase
      end
      if (psel && penable && pwrite)
      begin
         case (paddr)
            pin_mux_pkg::PORT1_MODE_SELECT_OFS:
               s_next.modeSelect = pwdata[7:0] & pin_mux_pkg::MODE_SELECT_MASK;
            pin_mux_pkg::PORT1_DIRECTION_OFS:
               s_next.p1Dir = pwdata[7:0] & pin_mux_pkg::PORT1_MASK;
            pin_mux_pkg::PORT1_DATA_OFS:
               s_next.p1Data = pwdata[7:0] & pin_mux_pkg::PORT1_MASK;
            pin_mux_pkg::PORT2_DIRECTION_OFS:
               s_next.p2Dir = pwdata[7:0] & pin_mux_pkg::PORT2_MASK;
            pin_mux_pkg::PORT2_OUTPUT_DATA_OFS:
               s_next.p2Data = pwdata[7:0] & pin_mux_pkg::PORT2_MASK;
            pin_mux_pkg::SERIAL_CTRL_OFS:
               s_next.serialCtrl = pwdata[7:0] & pin_mux_pkg::SERIAL_CTRL_MASK;
            default: s_next.rdata = s_reg.rdata;
         endcase
      end
   end

   // Reset clears every field, so all pins start as inputs
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   // Every access completes in its first access cycle; no wait states
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = s_reg.rdata;

   // Port 2 pins: alternate functions win over direction bits
   always_comb
   begin
      port2PinOut = s_reg.p2Data[2:0];
      port2PinOe = s_reg.p2Dir[2:0];
      // Transmit data takes P22 whatever its direction bit says
      if (txSel)
      begin
         port2PinOut[2] = txData;
         port2PinOe[2] = 1'b1;
      end
      if (rxSel)
         port2PinOe[1] = 1'b0;
      if (p20ClkIn)
         port2PinOe[0] = 1'b0;
      else if (p20ClkOut)
      begin
         port2PinOut[0] = serialClockOut;
         port2PinOe[0] = 1'b1;
      end
   end

   // Port 1 pins
   // P16, P15, P11 and P10 have no alternate function and keep the plain direction bit
   always_comb
   begin
      port1PinOut = s_reg.p1Data & pin_mux_pkg::PORT1_MASK;
      port1PinOe = s_reg.p1Dir & pin_mux_pkg::PORT1_MASK;
      if (int3Sel)
         port1PinOe[7] = 1'b0;
      if (int0Sel)
         port1PinOe[4] = 1'b0;
      if (p12ClkIn)
         port1PinOe[2] = 1'b0;
      else if (p12ClkOut)
      begin
         port1PinOut[2] = serialClockOutCh3;
         port1PinOe[2] = 1'b1;
      end
   end

   // Function inputs rest at their inactive level while the pin is ordinary I/O;
   // hand a pin over while it sits at that level or the function sees a false edge
   always_comb
   begin
      rxData = 1'b1;
      serialClockIn = 1'b1;
      serialClockInCh3 = 1'b1;
      extInterrupt3 = 1'b1;
      timerTriggerIn = 1'b0;
      extInterrupt0 = 1'b1;
      if (rxSel)
         rxData = p2Live[1];
      if (p20ClkIn)
         serialClockIn = p2Live[0];
      if (p12ClkIn)
         serialClockInCh3 = p1Live[2];
      if (int3Sel)
      begin
         extInterrupt3 = p1Live[7];
         timerTriggerIn = p1Live[7];
      end
      if (int0Sel)
         extInterrupt0 = p1Live[4];
   end
endmodule

// ==== design/pin_mux_pkg.sv ====
// Constants for the port 1 / port 2 pin-function multiplexer.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package pin_mux_pkg;
   localparam logic [11:0] PORT1_MODE_SELECT_OFS = 12'h000;
   localparam logic [11:0] PORT1_DIRECTION_OFS = 12'h004;
   localparam logic [11:0] PORT1_DATA_OFS = 12'h008;
   localparam logic [11:0] PORT2_DIRECTION_OFS = 12'h00C;
   localparam logic [11:0] PORT2_OUTPUT_DATA_OFS = 12'h010;
   localparam logic [11:0] SERIAL_CTRL_OFS = 12'h014;
   // Port 1 mode select fields
   localparam int MS_INT3_BIT = 7;
   localparam int MS_INT0_BIT = 4;
   localparam int MS_TXD_BIT = 1;
   localparam logic [7:0] MODE_SELECT_MASK = 8'h92;
   // Serial control register fields (channel A drives P20/P21, channel B drives P12)
   localparam int SC_CLKEN_LO_A = 0;
   localparam int SC_CLKEN_HI_A = 1;
   localparam int SC_COM_A = 2;
   localparam int SC_RXEN_A = 3;
   localparam int SC_CLKEN_LO_B = 4;
   localparam int SC_CLKEN_HI_B = 5;
   localparam int SC_COM_B = 6;
   localparam logic [7:0] SERIAL_CTRL_MASK = 8'h7F;
   localparam logic [7:0] PORT1_MASK = 8'hF7;
   localparam logic [7:0] PORT2_MASK = 8'h07;
   localparam logic [7:0] PORT1_RESERVED_ONES = 8'h08;
   localparam logic [7:0] PORT2_RESERVED_ONES = 8'hF8;
   localparam logic [7:0] RESET_VALUE = 8'h00;
endpackage

// ==== tb/pin_mux_checker.sv ====
// Port-level assertions for pin_mux.
// Assumes one clock domain; bound to every pin_mux instance.
module pin_mux_checker
(
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Direction
   input wire logic [11:0] paddr, // Address
   input wire logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic [7:0] port1PinOe, // P1 enable
   input wire logic [2:0] port2PinOe, // P2 enable
   input wire logic rxData, // Receive
   input wire logic serialClockIn, // Clock in
   input wire logic serialClockInCh3, // Clock in ch3
   input wire logic extInterrupt3, // Int 3
   input wire logic timerTriggerIn, // Trigger
   input wire logic extInterrupt0 // Int 0
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_ready; psel && penable |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("pready low in access");
   property p_err; psel && penable && paddr > 12'h014 |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("no error on unmapped address");
   property p_rsv; psel && !penable && !pwrite && paddr == 12'h010 |=> prdata[7:3] == 5'h1F;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved data bits not 1");
   property p_wo; psel && !penable && !pwrite && paddr == 12'h00C |=> prdata == 32'h0;
   endproperty
   a_wo: assert property (p_wo) else $error("direction register readable");
   property p_gpio; psel && penable && pwrite && paddr == 12'h004
      |=> {port1PinOe[6:5], port1PinOe[1:0]} == {$past(pwdata[6:5]), $past(pwdata[1:0])};
   endproperty
   a_gpio: assert property (p_gpio) else $error("plain pin enable wrong");
   property p_rx; port2PinOe[1] |-> rxData; endproperty
   a_rx: assert property (p_rx) else $error("receive active on output pin");
   property p_sck; port2PinOe[0] |-> serialClockIn; endproperty
   a_sck: assert property (p_sck) else $error("clock input on output pin");
   property p_serial_clock_pin; port1PinOe[2] |-> serialClockInCh3; endproperty
   a_serial_clock_pin: assert property (p_serial_clock_pin) else $error("ch3 clock input on output");
   property p_irq; port1PinOe[7] |-> extInterrupt3 && !timerTriggerIn; endproperty
   a_irq: assert property (p_irq) else $error("interrupt 3 on output pin");
   property p_ext_interrupt_0; port1PinOe[4] |-> extInterrupt0; endproperty
   a_ext_interrupt_0: assert property (p_ext_interrupt_0) else $error("interrupt 0 on output pin");
endmodule
bind pin_mux pin_mux_checker u_chk (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .port1PinOe, .port2PinOe, .rxData, .serialClockIn,
   .serialClockInCh3, .extInterrupt3, .timerTriggerIn, .extInterrupt0);

// ==== tb/pin_partner.sv ====
// Outside world of a port: resolves each pin from the block's drive and the board.
// Assumes the board always drives pins the block leaves as inputs.
module pin_partner #(parameter int W = 3)
(
   input wire logic [W-1:0] pinOut, // Block drive value
   input wire logic [W-1:0] pinOe, // Block drive enable
   input wire logic [W-1:0] extLevel, // Board level
   output logic [W-1:0] pinIn // Pin level
);
   timeunit 1ns;
   timeprecision 1ns;
   assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for pin_mux with APB register tasks.
// Assumes pin levels come through pin_partner.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] DIR2 = 12'h00C;
   localparam logic [11:0] DAT2 = 12'h010;
   localparam logic [11:0] SC = 12'h014;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, txData, rxData, serialClockOut;
   logic serialClockIn, serialClockOutCh3, serialClockInCh3, extInterrupt3, timerTriggerIn;
   logic extInterrupt0, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] port1PinIn, port1PinOut, port1PinOe, ext1;
   logic [2:0] port2PinIn, port2PinOut, port2PinOe, ext2;
   int miscompares = 0, samples_checked = 0;
   pin_mux u_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .port1PinIn, .port1PinOut, .port1PinOe, .port2PinIn, .port2PinOut, .port2PinOe,
      .txData, .rxData, .serialClockOut, .serialClockIn, .serialClockOutCh3, .serialClockInCh3,
      .extInterrupt3, .timerTriggerIn, .extInterrupt0);
   pin_partner #(.W(8)) u_p1 (.pinOut(port1PinOut), .pinOe(port1PinOe), .extLevel(ext1),
      .pinIn(port1PinIn));
   pin_partner #(.W(3)) u_p2 (.pinOut(port2PinOut), .pinOe(port2PinOe), .extLevel(ext2),
      .pinIn(port2PinIn));
   initial
   begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Waits for pready rather than assuming the single-cycle answer
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   task automatic t_gpio;
      chk("oe2", {port2PinOe, port2PinOut}, 32'h0);
      apb(0, DAT2, 8'h00);
      chk("live", rd, 32'hFC);
      apb(1, DAT2, 8'h06);
      apb(1, DIR2, 8'h07);
      chk("out2", {port2PinOe, port2PinOut}, 32'h3E);
      apb(0, DAT2, 8'h00);
      chk("latch", rd, 32'hFE);
      apb(0, DIR2, 8'h00);
      chk("wo", rd, 32'h0);
      $display("test gpio done");
   endtask
   task automatic t_serial;
      logic [7:0] sc[6] = '{8'h01, 8'h04, 8'h03, 8'h10, 8'h40, 8'h30};
      serialClockOut <= 1;
      serialClockOutCh3 <= 1;
      apb(1, DIR2, 8'h00);
      foreach (sc[i])
      begin
         apb(1, SC, sc[i]);
         chk("sck", {port2PinOe[0], port1PinOe[2]}, {!sc[i][1] && (sc[i][0] || sc[i][2]),
            !sc[i][5] && (sc[i][4] || sc[i][6])});
         chk("sckout", {port2PinOut[0], port1PinOut[2]}, {!sc[i][1] && (sc[i][0] || sc[i][2]),
            !sc[i][5] && (sc[i][4] || sc[i][6])});
      end
      txData <= 1;
      apb(1, DIR2, 8'h07);
      apb(1, SC, 8'h2A);
      apb(1, 12'h000, 8'h02);
      repeat (3) @(posedge clk);
      chk("alt", {port2PinOe, port2PinOut[2], rxData, serialClockIn, serialClockInCh3},
         {3'h4, 1'b1, ext2[1], ext2[0], ext1[2]});
      $display("test serial done");
   endtask
   task automatic t_port1;
      logic [7:0] lv[2] = '{8'h2B, 8'hBB};
      apb(1, 12'h004, 8'hFF);
      apb(1, 12'h000, 8'h90);
      foreach (lv[i])
      begin
         ext1 <= lv[i];
         repeat (3) @(posedge clk);
         chk("irq", {port1PinOe[7:4], port1PinOe[1:0], extInterrupt3, extInterrupt0,
            timerTriggerIn}, {6'h1B, lv[i][7], lv[i][4], lv[i][7]});
      end
      apb(1, 12'h008, 8'h5A);
      chk("p1out", port1PinOut, 32'h52);
      apb(0, 12'h008, 8'h00);
      chk("p1rd", rd, 32'h5A);
      apb(1, 12'h000, 8'h00);
      chk("gpio17", {port1PinOe[7], port1PinOe[4], extInterrupt3, extInterrupt0,
         timerTriggerIn}, 32'h1E);
      apb(1, 12'h020, 8'hFF);
      chk("err", er, 32'h1);
      $display("test port1 done");
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, txData, serialClockOut} = '0;
      serialClockOutCh3 = 0;
      ext1 = 8'h2B;
      ext2 = 3'h4;
      repeat (10) @(posedge clk);
      rst_n <= 1;
      repeat (3) @(posedge clk);
      t_gpio;
      t_serial;
      t_port1;
      print_verdict;
   end
   initial
   begin
      #2000000;
      miscompares++;
      print_verdict;
   end
endmodule
